// ---- core/sstp_front_end.sv ----
// stepper step-input front end: mode select, step decode, enable/fault pin
`timescale 1ns/1ps
module sstp_front_end (
   input  wire logic        core_clk,         // 25 MHz internal oscillator
   input  wire logic        rst,              // async reset, active high
   input  wire logic        sleep_hold,       // low = standby, high = run
   input  wire logic        cfg_pin_0,        // cfg_pin_0 / resolution_dir / serial data
   input  wire logic        cfg_pin_1,        // cfg_pin_1 / change enable / latch
   input  wire logic        cfg_pin_2,        // cfg_pin_2 / step clock / serial clock
   input  wire logic        cfg_pin_3,        // cfg_pin_3 / rotation_dir
   input  wire logic        en_pin_i,         // level seen on enable/fault pin
   output logic             en_pin_o,         // value driven on enable pin (0)
   output logic             en_pin_oe,        // high while pulling the pin low
   input  wire logic        thermal_trip,     // thermal detector level
   input  wire logic        overcurrent_trip, // overcurrent detector level
   input  wire logic        open_load_detect, // open-load detector level
   output logic             bridge_on,        // bridge transistors enabled
   output logic [8:0]       angle,            // electrical angle, 1/128 step units
   output logic [2:0]       step_res,         // 0 full ... 7 one 128th
   output logic             serial_mode,      // serial control selected
   output logic             ser_data,         // serial data, serial mode only
   output logic             ser_latch,        // latch enable, serial mode only
   output logic             ser_clk_rise,     // serial clock rising, one cycle
   input  wire logic        hsel,             // ahb slave select
   input  wire logic [31:0] haddr,            // ahb address
   input  wire logic [1:0]  htrans,           // ahb transfer type
   input  wire logic        hwrite,           // ahb write
   input  wire logic [2:0]  hsize,            // ahb size
   input  wire logic [31:0] hwdata,           // ahb write data
   input  wire logic        hready,           // ahb bus ready
   output logic             hreadyout,        // ahb slave ready
   output logic             hresp,            // ahb response
   output logic [31:0]      hrdata,           // ahb read data
   output logic             irq               // level interrupt
);

   // synchroniser stages
   logic [sstp_pkg::PIN_N-1:0] pin_raw;     // raw pin levels
   logic [sstp_pkg::PIN_N-1:0] meta_reg;    // first stage, read only by sync_reg
   logic [sstp_pkg::PIN_N-1:0] sync_reg;    // second stage, safe to use
   logic [sstp_pkg::PIN_N-1:0] last_reg;    // delayed copy for edge detect

   // mode and stepping state
   sstp_pkg::sstp_phase_t       phase_reg;   // standby / hold / run
   logic [sstp_pkg::HOLD_CNT_W-1:0] hold_cnt_reg; // hold-time counter
   logic                        serial_reg;  // latched control mode
   logic                        fixed_reg;   // fixed resolution mode
   logic [2:0]                  res_max_reg; // finest allowed resolution
   logic [2:0]                  res_reg;     // current resolution
   logic [8:0]                  angle_reg;   // electrical angle

   // registers
   logic [31:0]                 ctrl_reg;    // control
   logic [sstp_pkg::ST_W-1:0]   stat_reg;    // sticky fault status
   logic [sstp_pkg::ST_W-1:0]   mask_reg;    // interrupt mask

   // bus data phase capture
   logic                        dp_wr_reg;   // write pending in data phase
   logic [7:0]                  dp_addr_reg; // its byte offset

   // decoded strobes
   logic                        step_rise;   // step clock rising
   logic                        sclk_rise;   // serial clock rising
   logic                        running;     // pin roles assigned
   logic                        wake;        // standby released
   logic [sstp_pkg::ST_W-1:0]   fault_now;   // live fault events
   logic [sstp_pkg::ST_W-1:0]   w1c;         // bits cleared by software
   logic                        a_sel;       // valid address phase
   logic [31:0]                 rd_val;      // read mux

   // step size in 1/128 units for a resolution code
   function automatic logic [8:0] step_size(input logic [2:0] res);
      step_size = 9'h080 >> res;
   endfunction

   // decoded control mode of four sampled pins
   function automatic logic is_serial(input logic [3:0] cfg);
      is_serial = (cfg == 4'h0);
   endfunction

   assign pin_raw = {en_pin_i, sleep_hold, cfg_pin_3, cfg_pin_2, cfg_pin_1, cfg_pin_0};

   // two-flop synchronisers, one per pin
   genvar gi;
   generate
      for (gi = 0; gi < sstp_pkg::PIN_N; gi++)
      begin : g_sync
         always_ff @(posedge core_clk or posedge rst)
         begin
            if (rst)
            begin
               meta_reg[gi] <= 1'b0;
               sync_reg[gi] <= 1'b0;
               last_reg[gi] <= 1'b0;
            end
            else
            begin
               meta_reg[gi] <= pin_raw[gi];
               sync_reg[gi] <= meta_reg[gi];
               last_reg[gi] <= sync_reg[gi];
            end
         end
      end
   endgenerate

   // edges only from the second stage onward
   assign wake    = sync_reg[sstp_pkg::PIN_SLEEP] & ~last_reg[sstp_pkg::PIN_SLEEP];
   assign running = (phase_reg == sstp_pkg::SSTP_RUN);
   // step clock and serial clock share one pin; the latched mode picks the role
   assign step_rise = running & ~serial_reg & sync_reg[sstp_pkg::PIN_CFG2]
                      & ~last_reg[sstp_pkg::PIN_CFG2];
   assign sclk_rise = running & serial_reg & sync_reg[sstp_pkg::PIN_CFG2]
                      & ~last_reg[sstp_pkg::PIN_CFG2];

   // mode selection: sample once at wake, then wait out the hold window
   always_ff @(posedge core_clk or posedge rst)
   begin
      if (rst)
      begin
         phase_reg    <= sstp_pkg::SSTP_STANDBY;
         hold_cnt_reg <= '0;
         serial_reg   <= 1'b0;
         fixed_reg    <= 1'b0;
         res_max_reg  <= sstp_pkg::RES_FULL;
      end
      else if (!sync_reg[sstp_pkg::PIN_SLEEP])
      begin
         // standby low returns the phase to standby and clears the hold count; latched faults stay
         phase_reg    <= sstp_pkg::SSTP_STANDBY;
         hold_cnt_reg <= '0;
      end
      else
      begin
         case (phase_reg)
            sstp_pkg::SSTP_STANDBY:
            begin
               if (wake)
               begin
                  // sampled just after release; the host keeps pins still
                  serial_reg  <= is_serial(sync_reg[3:0]);
                  fixed_reg   <= sync_reg[sstp_pkg::PIN_CFG3];
                  res_max_reg <= sync_reg[2:0];
                  phase_reg   <= sstp_pkg::SSTP_HOLD;
               end
            end
            sstp_pkg::SSTP_HOLD:
            begin
               // pins still carry mode levels: no role change yet
               if (hold_cnt_reg == sstp_pkg::HOLD_CNT_W'(sstp_pkg::MODE_HOLD_CYC - 1))
               begin
                  phase_reg <= sstp_pkg::SSTP_RUN;
               end
               else
               begin
                  hold_cnt_reg <= hold_cnt_reg + 1'b1;
               end
            end
            sstp_pkg::SSTP_RUN:
            begin
               phase_reg <= sstp_pkg::SSTP_RUN;
            end
            default:
            begin
               phase_reg <= sstp_pkg::SSTP_STANDBY;
            end
         endcase
      end
   end

   // resolution: fixed mode keeps the sampled one, variable starts full
   always_ff @(posedge core_clk or posedge rst)
   begin
      if (rst)
      begin
         res_reg <= sstp_pkg::RES_FULL;
      end
      else if (phase_reg != sstp_pkg::SSTP_RUN)
      begin
         res_reg <= fixed_reg ? res_max_reg : sstp_pkg::RES_FULL;
      end
      else if (step_rise && !fixed_reg && sync_reg[sstp_pkg::PIN_CFG1])
      begin
         if (!sync_reg[sstp_pkg::PIN_CFG0])
         begin
            // finer, capped at the sampled finest
            if (res_reg < res_max_reg)
            begin
               res_reg <= res_reg + 1'b1;
            end
         end
         else if (res_reg != sstp_pkg::RES_FULL)
         begin
            res_reg <= res_reg - 1'b1;
         end
      end
   end

   // electrical angle: the step taken uses the resolution before any change
   always_ff @(posedge core_clk or posedge rst)
   begin
      if (rst)
      begin
         angle_reg <= '0;
      end
      else if (!sync_reg[sstp_pkg::PIN_SLEEP])
      begin
         angle_reg <= '0;
      end
      else if (step_rise)
      begin
         if (sync_reg[sstp_pkg::PIN_CFG3])
         begin
            angle_reg <= angle_reg + step_size(res_reg);
         end
         else
         begin
            angle_reg <= angle_reg - step_size(res_reg);
         end
      end
   end

   // live fault events; open-load only counts in serial mode
   assign fault_now[sstp_pkg::ST_THERMAL]  = thermal_trip;
   assign fault_now[sstp_pkg::ST_OVERCUR]  = overcurrent_trip;
   assign fault_now[sstp_pkg::ST_OPENLOAD] = open_load_detect & serial_reg & running;

   // bus address phase accepted
   assign a_sel = hsel & htrans[1] & hready;
   assign w1c   = (dp_wr_reg && dp_addr_reg == sstp_pkg::STAT_OFS) ?
                  hwdata[sstp_pkg::ST_W-1:0] : '0;

   // sticky status: a fault in the clearing cycle stays set
   always_ff @(posedge core_clk or posedge rst)
   begin
      if (rst)
      begin
         stat_reg <= '0;
      end
      else
      begin
         stat_reg <= (stat_reg & ~w1c) | fault_now;
      end
   end

   // data phase bookkeeping; zero wait states so hready always high
   always_ff @(posedge core_clk or posedge rst)
   begin
      if (rst)
      begin
         dp_wr_reg   <= 1'b0;
         dp_addr_reg <= 8'h00;
      end
      else
      begin
         dp_wr_reg   <= a_sel & hwrite;
         dp_addr_reg <= haddr[7:0];
      end
   end

   // writable registers
   always_ff @(posedge core_clk or posedge rst)
   begin
      if (rst)
      begin
         ctrl_reg <= sstp_pkg::CTRL_RST;
         mask_reg <= sstp_pkg::MASK_RST;
      end
      else if (dp_wr_reg)
      begin
         case (dp_addr_reg)
            sstp_pkg::CTRL_OFS: ctrl_reg <= {31'h0000_0000, hwdata[sstp_pkg::CTRL_SOFT_OFF]};
            sstp_pkg::MASK_OFS: mask_reg <= hwdata[sstp_pkg::ST_W-1:0];
            default:            ctrl_reg <= ctrl_reg;
         endcase
      end
   end

   // read mux; unmapped offsets read zero
   always_comb
   begin
      rd_val = 32'h0000_0000;
      case (haddr[7:0])
         sstp_pkg::CTRL_OFS:  rd_val = ctrl_reg;
         sstp_pkg::STAT_OFS:  rd_val[sstp_pkg::ST_W-1:0] = stat_reg;
         sstp_pkg::MASK_OFS:  rd_val[sstp_pkg::ST_W-1:0] = mask_reg;
         sstp_pkg::STATE_OFS:
         begin
            rd_val[sstp_pkg::SF_ANGLE +: 9]   = angle_reg;
            rd_val[sstp_pkg::SF_RES +: 3]     = res_reg;
            rd_val[sstp_pkg::SF_RES_MAX +: 3] = res_max_reg;
            rd_val[sstp_pkg::SF_SERIAL]       = serial_reg;
            rd_val[sstp_pkg::SF_RUN]          = running;
            rd_val[sstp_pkg::SF_BRIDGE]       = bridge_on;
         end
         default:             rd_val = 32'h0000_0000;
      endcase
   end

   // read data registered at the address phase, stands in the data phase
   always_ff @(posedge core_clk or posedge rst)
   begin
      if (rst)
      begin
         hrdata <= 32'h0000_0000;
      end
      else if (a_sel && !hwrite)
      begin
         hrdata <= rd_val;
      end
   end

   assign hreadyout = 1'b1;
   assign hresp     = 1'b0;
   assign irq       = |(stat_reg & mask_reg);

   // pin-facing outputs, all from flops
   always_ff @(posedge core_clk or posedge rst)
   begin
      if (rst)
      begin
         en_pin_oe    <= 1'b0;
         bridge_on    <= 1'b0;
         ser_data     <= 1'b0;
         ser_latch    <= 1'b0;
         ser_clk_rise <= 1'b0;
      end
      else
      begin
         // a latched fault pulls the shared pin low until cleared
         en_pin_oe    <= |stat_reg;
         // external low, our own pull-down or soft-off all kill the bridge
         bridge_on    <= running & sync_reg[sstp_pkg::PIN_EN] & ~(|stat_reg)
                         & ~ctrl_reg[sstp_pkg::CTRL_SOFT_OFF];
         ser_data     <= running & serial_reg & sync_reg[sstp_pkg::PIN_CFG0];
         ser_latch    <= running & serial_reg & sync_reg[sstp_pkg::PIN_CFG1];
         ser_clk_rise <= sclk_rise;
      end
   end

   assign en_pin_o    = 1'b0;
   assign angle       = angle_reg;
   assign step_res    = res_reg;
   assign serial_mode = serial_reg;

endmodule

// ---- core/sstp_pkg.sv ----
// constants for the stepper step-input front end
package sstp_pkg;
   // core clock rate and derived pin timing
   localparam int CLK_HZ            = 25_000_000;
   localparam int MODE_HOLD_US      = 100;
   localparam int MODE_HOLD_CYC     = (MODE_HOLD_US * (CLK_HZ / 1_000_000));
   localparam int MODE_SETUP_US     = 1;
   localparam int HOLD_CNT_W        = 12;

   // register byte offsets
   localparam logic [7:0] CTRL_OFS  = 8'h00;
   localparam logic [7:0] STAT_OFS  = 8'h04;
   localparam logic [7:0] MASK_OFS  = 8'h08;
   localparam logic [7:0] STATE_OFS = 8'h0C;

   // status / mask bit positions
   localparam int ST_THERMAL        = 0;
   localparam int ST_OVERCUR        = 1;
   localparam int ST_OPENLOAD       = 2;
   localparam int ST_W              = 3;

   // control bit positions and reset values
   localparam int CTRL_SOFT_OFF     = 0;
   localparam logic [31:0] CTRL_RST = 32'h0000_0000;
   localparam logic [ST_W-1:0] MASK_RST = 3'h0;

   // state register field positions
   localparam int SF_ANGLE          = 0;
   localparam int SF_RES            = 12;
   localparam int SF_RES_MAX        = 16;
   localparam int SF_SERIAL         = 20;
   localparam int SF_RUN            = 21;
   localparam int SF_BRIDGE         = 22;

   // electrical angle in 1/128 step units, four full steps per cycle
   localparam int ANGLE_W           = 9;
   localparam int RES_W             = 3;
   localparam logic [RES_W-1:0] RES_FULL = 3'h0;
   localparam logic [RES_W-1:0] RES_FINEST = 3'h7;

   // synchronised pin indexes
   localparam int PIN_CFG0          = 0;
   localparam int PIN_CFG1          = 1;
   localparam int PIN_CFG2          = 2;
   localparam int PIN_CFG3          = 3;
   localparam int PIN_SLEEP         = 4;
   localparam int PIN_EN            = 5;
   localparam int PIN_N             = 6;

   // front-end phases
   typedef enum logic [1:0] {
      SSTP_STANDBY,
      SSTP_HOLD,
      SSTP_RUN
   } sstp_phase_t;
endpackage

// ---- dv/sstp_assertions.sv ----
// checker watching the stepper front end at its pins
`timescale 1ns/1ps
module sstp_assertions (
   input wire logic       core_clk,         // core clock
   input wire logic       rst,              // async reset
   input wire logic       sleep_hold,       // standby pin
   input wire logic       cfg_pin_0,        // resolution_dir in step mode
   input wire logic       cfg_pin_1,        // change enable in step mode
   input wire logic       cfg_pin_2,        // step clock
   input wire logic       cfg_pin_3,        // rotation_dir
   input wire logic       en_pin_i,         // enable pin level
   input wire logic       en_pin_oe,        // pin pulled low
   input wire logic       thermal_trip,     // thermal detector
   input wire logic       overcurrent_trip, // overcurrent detector
   input wire logic       open_load_detect, // open-load detector
   input wire logic       bridge_on,        // bridges enabled
   input wire logic [8:0] angle,            // electrical angle
   input wire logic [2:0] step_res,         // resolution code
   input wire logic       serial_mode,      // serial selected
   input wire logic       ser_data,         // serial data copy
   input wire logic       ser_latch,        // latch copy
   input wire logic       ser_clk_rise      // serial clock pulse
);
   localparam int WAKE_SETTLE = 2560; // past the mode hold, so run state is reached
   logic [11:0] awake_cnt;            // cycles since wake, saturating
   logic        awake;                // run reached, mode load finished
   // wake timer; step checks wait for it since mode load may move res
   always_ff @(posedge core_clk or posedge rst)
   begin
      if (rst)
      begin
         awake_cnt <= 12'h000;
      end
      else if (!sleep_hold)
      begin
         awake_cnt <= 12'h000;
      end
      else if (awake_cnt < 12'(WAKE_SETTLE))
      begin
         awake_cnt <= awake_cnt + 12'h001;
      end
   end
   assign awake = (awake_cnt >= 12'(WAKE_SETTLE));
   default clocking cb @(posedge core_clk);
   endclocking
   default disable iff (rst);
   a_step_up: assert property (awake && !$stable(angle) && $past(cfg_pin_3, 3)
      |-> angle == 9'($past(angle) + (9'h080 >> $past(step_res))))
      else $error("angle did not step up by one step");
   a_step_down: assert property (awake && !$stable(angle) && !$past(cfg_pin_3, 3)
      |-> angle == 9'($past(angle) - (9'h080 >> $past(step_res))))
      else $error("angle did not step down by one step");
   a_no_fall_step: assert property (awake && !$stable(angle)
      |-> $past(cfg_pin_2, 3) || $past(cfg_pin_2, 4))
      else $error("angle moved without a step clock rise");
   a_serial_still: assert property (awake && serial_mode |-> $stable(angle))
      else $error("angle moved in serial mode");
   a_res_on_step: assert property (awake && !$stable(step_res) |-> !$stable(angle))
      else $error("resolution changed off a step edge");
   a_res_enable: assert property (awake && !$stable(step_res)
      |-> $past(cfg_pin_1, 3) && ((step_res > $past(step_res)) == !$past(cfg_pin_0, 3)))
      else $error("resolution change without enable or wrong way");
   a_en_off: assert property (!en_pin_i [*4] |-> !bridge_on)
      else $error("bridge on while enable pin low");
   a_en_on: assert property (bridge_on |-> $past(en_pin_i, 3))
      else $error("bridge on without enable pin high");
   a_fault_off: assert property (en_pin_oe |-> !bridge_on)
      else $error("bridge on while flagging a fault");
   a_trip_flag: assert property (thermal_trip || overcurrent_trip |-> ##[1:3] en_pin_oe)
      else $error("trip not flagged on enable pin");
   a_flag_cause: assert property ($rose(en_pin_oe) |-> $past(thermal_trip, 2)
      || $past(overcurrent_trip, 2) || ($past(open_load_detect, 2) && $past(serial_mode, 2)))
      else $error("fault flag without a valid cause");
   a_ser_quiet: assert property (!serial_mode |-> !ser_clk_rise && !ser_data && !ser_latch)
      else $error("serial outputs active in step mode");
   c_step: cover property (awake && !$stable(angle));
   c_res: cover property (awake && !$stable(step_res));
   c_flag: cover property ($rose(en_pin_oe));
   c_ser: cover property (ser_clk_rise);
endmodule
bind sstp_front_end sstp_assertions chk (.core_clk, .rst, .sleep_hold, .cfg_pin_0,
   .cfg_pin_1, .cfg_pin_2, .cfg_pin_3, .en_pin_i, .en_pin_oe, .thermal_trip,
   .overcurrent_trip, .open_load_detect, .bridge_on, .angle, .step_res, .serial_mode,
   .ser_data, .ser_latch, .ser_clk_rise);

// ---- dv/sstp_host_model.sv ----
// host controller model driving standby, mode and step pins
`timescale 1ns/1ps
module sstp_host_model (
   input  wire logic core_clk,   // core clock
   output logic      sleep_hold, // standby pin
   output logic [3:0] cfg,       // shared mode / role pins
   output logic      en_drive_n  // low pulls the enable pin low
);
   // standby, motor off, pins quiet at time zero
   initial
   begin
      sleep_hold = 1'b0;
      cfg = 4'h0;
      en_drive_n = 1'b0;
   end
   // standby, then wake with a mode code held around the release edge
   task automatic wake(input logic [3:0] m);
      en_drive_n <= 1'b0; // outputs off until settled
      sleep_hold <= 1'b0;
      repeat (4) @(posedge core_clk);
      cfg <= m;
      repeat (30) @(posedge core_clk); // setup beyond 1 us
      sleep_hold <= 1'b1;
      repeat (2560) @(posedge core_clk); // hold beyond 100 us
      cfg <= 4'h0;
      en_drive_n <= 1'b1; // release pin; pull-up enables
      repeat (4) @(posedge core_clk);
   endtask
   // one pin in its run role
   task automatic set_cfg(input int i, input logic v);
      cfg[i] <= v;
   endtask
   // enable pin: drive low or let the pull-up win
   task automatic set_en(input logic v);
      en_drive_n <= v;
   endtask
   // one step clock pulse, three cycles high and three low
   task automatic step;
      cfg[2] <= 1'b1;
      repeat (3) @(posedge core_clk);
      cfg[2] <= 1'b0;
      repeat (3) @(posedge core_clk);
   endtask
endmodule

// ---- dv/testbench.sv ----
// self-checking bench for the stepper front end
`timescale 1ns/1ps
module testbench;
   logic        core_clk, rst;          // clock and reset
   logic        sleep_hold, en_drive_n; // host model pins
   logic [3:0]  cfg;                    // shared pins
   wire logic   en_pin_i;               // resolved enable pin
   logic        en_pin_o, en_pin_oe;    // dut side of enable pin
   logic [2:0]  trip;                   // thermal, overcurrent, open-load
   logic        bridge_on, serial_mode; // status outputs
   logic [8:0]  angle;                  // electrical angle
   logic [2:0]  step_res;               // resolution code
   logic        ser_data, ser_latch, ser_clk_rise; // serial outputs
   logic        hsel, hwrite;           // bus controls
   logic [1:0]  htrans;                 // transfer type
   logic [2:0]  hsize;                  // transfer size, whole word in address phase
   logic [31:0] haddr, hwdata, hrdata;  // bus words
   logic        hreadyout, hresp, irq;  // slave outputs
   wire logic   hready;                 // single slave drives bus ready
   int          fail_count, num_checks, cyc; // tallies
   logic [31:0] q;                      // scratch read data
   assign hready = hreadyout;
   // pull-up pin: low if host or dut pulls it
   assign en_pin_i = en_drive_n & (en_pin_oe ? en_pin_o : 1'b1);
   sstp_host_model host (.core_clk(core_clk), .sleep_hold(sleep_hold), .cfg(cfg),
      .en_drive_n(en_drive_n));
   sstp_front_end dut (.core_clk(core_clk), .rst(rst), .sleep_hold(sleep_hold),
      .cfg_pin_0(cfg[0]), .cfg_pin_1(cfg[1]), .cfg_pin_2(cfg[2]), .cfg_pin_3(cfg[3]),
      .en_pin_i(en_pin_i), .en_pin_o(en_pin_o), .en_pin_oe(en_pin_oe),
      .thermal_trip(trip[0]), .overcurrent_trip(trip[1]), .open_load_detect(trip[2]),
      .bridge_on(bridge_on), .angle(angle), .step_res(step_res),
      .serial_mode(serial_mode), .ser_data(ser_data), .ser_latch(ser_latch),
      .ser_clk_rise(ser_clk_rise), .hsel(hsel), .haddr(haddr), .htrans(htrans),
      .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
      .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .irq(irq));
   // 25 MHz clock
   initial
   begin
      core_clk = 1'b0;
      forever #20 core_clk = ~core_clk;
   end
   task automatic close_out;
      $display("checks %0d mismatches %0d", num_checks, fail_count);
      if (fail_count == 0 && num_checks > 0)
      begin
         $display("Finished cleanly");
      end
      else
      begin
         $display("Finished with errors");
      end
      $finish;
   endtask
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      num_checks++;
      if (seen !== exp)
      begin
         fail_count++;
         $display("mismatch at %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   // one single-word transfer; waits on ready, no fixed latency assumed
   task automatic bus(input logic wr, input logic [31:0] a, input logic [31:0] d);
      hsel <= 1'b1;
      haddr <= a;
      htrans <= 2'h2;
      hwrite <= wr;
      hsize <= 3'h2;
      do @(posedge core_clk); while (hready !== 1'b1);
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= d;
      do @(posedge core_clk); while (hready !== 1'b1);
      q = hrdata;
   endtask
   task automatic rdchk(input logic [31:0] a, input logic [31:0] exp);
      bus(1'b0, a, 32'h0);
      check(q, exp);
      check(32'(hresp), 32'h0);
   endtask
   task automatic waitc(input int n);
      repeat (n) @(posedge core_clk);
   endtask
   task automatic stp(input logic [8:0] ea, input logic [2:0] er);
      host.step();
      check(32'(angle), 32'(ea));
      check(32'(step_res), 32'(er));
   endtask
   // variable mode up to 1/8: steps, falls, direction, resolution moves
   task automatic t_pulse;
      host.wake(4'h3);
      check(32'(serial_mode), 32'h0);
      rdchk(32'(sstp_pkg::STATE_OFS), 32'h0063_0000);
      host.set_cfg(3, 1'b1);
      stp(9'h080, 3'h0);
      host.set_cfg(2, 1'b1);
      waitc(6);
      check(32'(angle), 32'h100);
      host.set_cfg(2, 1'b0);
      waitc(6);
      check(32'(angle), 32'h100);
      host.set_cfg(3, 1'b0);
      host.set_cfg(1, 1'b1);
      stp(9'h080, 3'h1);
      stp(9'h040, 3'h2);
      stp(9'h020, 3'h3);
      stp(9'h010, 3'h3);
      host.set_cfg(0, 1'b1);
      stp(9'h000, 3'h2);
      host.set_cfg(0, 1'b0);
      host.set_cfg(1, 1'b0);
      stp(9'h1E0, 3'h2);
   endtask
   // enable pin and the soft-off control bit
   task automatic t_enable;
      host.set_en(1'b0);
      waitc(6);
      check(32'(bridge_on), 32'h0);
      host.set_en(1'b1);
      waitc(6);
      check(32'(bridge_on), 32'h1);
      bus(1'b1, 32'(sstp_pkg::CTRL_OFS), 32'h1);
      waitc(3);
      check(32'(bridge_on), 32'h0);
      rdchk(32'(sstp_pkg::CTRL_OFS), 32'h1);
      bus(1'b1, 32'(sstp_pkg::CTRL_OFS), 32'h0);
   endtask
   // trips: flag, interrupt mask, clear; open-load dropped in step mode
   task automatic t_fault;
      bus(1'b1, 32'(sstp_pkg::MASK_OFS), 32'h7);
      for (int i = 0; i < 2; i++)
      begin
         trip[i] <= 1'b1;
         waitc(4);
         trip[i] <= 1'b0;
         waitc(2);
         check(32'(en_pin_oe), 32'h1);
         check(32'(bridge_on), 32'h0);
         check(32'(en_pin_i), 32'h0);
         check(32'(irq), 32'h1);
         rdchk(32'(sstp_pkg::STAT_OFS), 32'(1 << i));
         bus(1'b1, 32'(sstp_pkg::MASK_OFS), 32'h0);
         waitc(1);
         check(32'(irq), 32'h0);
         bus(1'b1, 32'(sstp_pkg::MASK_OFS), 32'h7);
         bus(1'b1, 32'(sstp_pkg::STAT_OFS), 32'(1 << i));
         waitc(3);
         check(32'(en_pin_oe), 32'h0);
      end
      trip[2] <= 1'b1;
      waitc(4);
      trip[2] <= 1'b0;
      waitc(2);
      rdchk(32'(sstp_pkg::STAT_OFS), 32'h0);
   endtask
   // serial mode: pin roles, no stepping, open-load seen
   task automatic t_serial;
      int n;
      host.wake(4'h0);
      check(32'(serial_mode), 32'h1);
      host.set_cfg(0, 1'b1);
      host.set_cfg(1, 1'b1);
      host.set_cfg(2, 1'b1);
      n = 0;
      repeat (8)
      begin
         @(posedge core_clk);
         n = n + int'(ser_clk_rise);
      end
      check(32'(n), 32'h1);
      check(32'(ser_data), 32'h1);
      check(32'(ser_latch), 32'h1);
      check(32'(angle), 32'h0);
      trip[2] <= 1'b1;
      waitc(4);
      trip[2] <= 1'b0;
      waitc(2);
      rdchk(32'(sstp_pkg::STAT_OFS), 32'h4);
      bus(1'b1, 32'(sstp_pkg::STAT_OFS), 32'h4);
   endtask
   // timeout; a hang counts as a mismatch
   always @(posedge core_clk)
   begin
      cyc++;
      if (cyc == 12000)
      begin
         fail_count++;
         close_out();
      end
   end
   initial
   begin
      rst = 1'b1;
      hsel = 1'b0;
      haddr = 32'h0;
      htrans = 2'h0;
      hsize = 3'h0;
      hwrite = 1'b0;
      hwdata = 32'h0;
      trip = 3'h0;
      fail_count = 0;
      num_checks = 0;
      cyc = 0;
      repeat (20) @(posedge core_clk);
      rst <= 1'b0;
      @(posedge core_clk);
      for (int i = 0; i < 5; i++)
      begin
         rdchk(32'(i * 4), 32'h0); // reset values; 0x10 is unmapped
      end
      t_pulse();
      t_enable();
      t_fault();
      t_serial();
      host.wake(4'hB);
      host.set_cfg(3, 1'b1);
      stp(9'h010, 3'h3);
      close_out();
   end
endmodule
